// ### stk_top.v
`timescale 1ns/1ps
`default_nettype none
`include "stk_map.vh"

// System tick timer with an APB slave port.
module stk_top #(
    parameter CNT_W = `STK_CNT_W
) (
    input  wire        CLOCK,
    input  wire        RST_B,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        HANDLER_ENTRY,
    output reg         TICK_IRQ,
    output reg         EVENT_IRQ
);

    reg  [1:0]           ctrl_q;
    reg  [CNT_W:0]       period_q;
    reg                  pend_q;
    reg  [`STK_EV_W-1:0] status_q;
    reg  [`STK_EV_W-1:0] mask_q;
    reg  [31:0]          rdata_d;
    reg                  slverr_d;
    reg  [`STK_EV_W-1:0] status_d;
    reg                  pend_d;
    wire                 setup;
    wire                 wr;
    wire                 rd;
    wire                 cur_write;
    wire                 run;
    wire                 rollover;
    wire                 reload_pend;
    wire [CNT_W-1:0]     count;
    wire [`STK_EV_W-1:0] events;

    // Zero-wait-state slave: the decode happens in setup so PREADY can be a flop.
    assign setup     = PSEL & ~PENABLE;
    assign wr        = PSEL & PENABLE & PWRITE & PREADY;
    assign rd        = PSEL & PENABLE & ~PWRITE & PREADY;
    assign cur_write = wr & (PADDR == `STK_OFF_CURRENT);
    assign run       = ctrl_q[`STK_CTRL_ENABLE];
    // Bit one marks a pending reload being taken, bit zero a rollover.
    assign events    = {run & reload_pend & ~cur_write, rollover};

    stk_counter #(
        .CNT_W (CNT_W)
    ) u_counter (
        .clk           (CLOCK),
        .rst_b         (RST_B),
        .run           (run),
        .force_clr     (cur_write),
        .period        (period_q),
        .count_q       (count),
        .rollover_q    (rollover),
        .reload_pend_q (reload_pend)
    );

    // Read data mux, prepared during setup so it is registered at the access.
    always @* begin
        rdata_d  = 32'h00000000;
        slverr_d = 1'b0;
        case (PADDR)
            `STK_OFF_CTRL:    rdata_d[1:0] = ctrl_q;
            `STK_OFF_PERIOD:  rdata_d[CNT_W:0] = period_q;
            `STK_OFF_CURRENT: rdata_d[CNT_W-1:0] = count;
            `STK_OFF_STATUS:  rdata_d[`STK_EV_W-1:0] = status_q;
            `STK_OFF_MASK:    rdata_d[`STK_EV_W-1:0] = mask_q;
            default:          slverr_d = 1'b1;
        endcase
    end

    // Sticky status: a read clears only the bits that it reported, so an event
    // landing between setup and access is not lost; a same-cycle event wins.
    // The tick pending bit is cleared by handler entry; a new rollover wins.
    always @* begin
        status_d = status_q;
        if (rd && PADDR == `STK_OFF_STATUS)
            status_d = status_q & ~PRDATA[`STK_EV_W-1:0];
        status_d = status_d | events;
        pend_d = pend_q;
        if (HANDLER_ENTRY)
            pend_d = 1'b0;
        if (rollover)
            pend_d = 1'b1;
    end

    // Bus and register state.
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            ctrl_q    <= `STK_CTRL_RST;
            period_q  <= `STK_PERIOD_RST;
            mask_q    <= `STK_MASK_RST;
            status_q  <= {`STK_EV_W{1'b0}};
            pend_q    <= 1'b0;
            PRDATA    <= 32'h00000000;
            PREADY    <= 1'b0;
            PSLVERR   <= 1'b0;
            TICK_IRQ  <= 1'b0;
            EVENT_IRQ <= 1'b0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & slverr_d;
            if (setup)
                PRDATA <= rdata_d;
            if (wr && PADDR == `STK_OFF_CTRL)
                ctrl_q <= PWDATA[1:0];
            if (wr && PADDR == `STK_OFF_PERIOD)
                period_q <= PWDATA[CNT_W:0];
            if (wr && PADDR == `STK_OFF_MASK)
                mask_q <= PWDATA[`STK_EV_W-1:0];
            status_q  <= status_d;
            pend_q    <= pend_d;
            // Pending only forwarded while tick interrupts are enabled.
            TICK_IRQ  <= pend_d & ctrl_q[`STK_CTRL_TICKIE];
            EVENT_IRQ <= |(status_d & mask_q);
        end
    end

endmodule // stk_top

`default_nettype wire

// ### stk_map.vh
// Operation
// - Disable stops counting and new tick events
// - Enable resumes from current count, reloading first only if a reload is pending
// - Each rollover raises the tick event
// - Current write clears counter, reload next enabled clock
// - New period applies only at next reload
// - Period equals clocks between successive rollovers
// - Current count reads period minus one..zero
// - Interrupt reaches processor only while enabled
// - Pending tick cleared when handler entered
// - Programmed period is readable back
`ifndef STK_MAP_VH
`define STK_MAP_VH

`define STK_OFF_CTRL     12'h000
`define STK_OFF_PERIOD   12'h004
`define STK_OFF_CURRENT  12'h008
`define STK_OFF_STATUS   12'h00C
`define STK_OFF_MASK     12'h010

`define STK_CTRL_ENABLE  0
`define STK_CTRL_TICKIE  1

`define STK_CNT_W        24
`define STK_PERIOD_RST   25'h0000001
`define STK_CTRL_RST     2'h0
`define STK_MASK_RST     2'h0

`define STK_EV_TICK      0
`define STK_EV_RELOAD    1
`define STK_EV_W         2

`endif

// ### stk_counter.v
`timescale 1ns/1ps
`default_nettype none

// Down-counter core. The counter holds period minus one down to zero.
module stk_counter #(
    parameter CNT_W = 24
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire             run,
    input  wire             force_clr,
    input  wire [CNT_W:0]   period,
    output reg  [CNT_W-1:0] count_q,
    output reg              rollover_q,
    output reg              reload_pend_q
);

    reg [CNT_W-1:0] count_d;
    reg             rollover_d;
    reg             reload_pend_d;
    wire [CNT_W-1:0] reload_val;

    // Period of N gives N clocks per cycle, so load N-1.
    assign reload_val = period[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

    // A forced clear parks the counter at zero with a reload pending; the reload
    // uses whatever period is current at that moment, never a stale copy.
    always @* begin
        count_d       = count_q;
        rollover_d    = 1'b0;
        reload_pend_d = reload_pend_q;
        if (force_clr) begin
            count_d       = {CNT_W{1'b0}};
            reload_pend_d = 1'b1;
        end else if (run) begin
            if (reload_pend_q) begin
                count_d       = reload_val;
                reload_pend_d = 1'b0;
            end else if (count_q == {CNT_W{1'b0}}) begin
                count_d    = reload_val;
                rollover_d = 1'b1;
            end else begin
                count_d = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // State registers.
    always @(posedge clk) begin
        if (!rst_b) begin
            count_q       <= {CNT_W{1'b0}};
            rollover_q    <= 1'b0;
            reload_pend_q <= 1'b1;
        end else begin
            count_q       <= count_d;
            rollover_q    <= rollover_d;
            reload_pend_q <= reload_pend_d;
        end
    end

endmodule // stk_counter

`default_nettype wire

// ### stk_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks; the delays are the registered output latencies of the timer.
module stk_chk #(parameter CNT_W = 24) (
    input wire logic        CLOCK,
    input wire logic        RST_B,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        HANDLER_ENTRY,
    input wire logic        TICK_IRQ,
    input wire logic        EVENT_IRQ
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    sequence s_set; PSEL && !PENABLE; endsequence
    sequence s_cwr; PSEL && PREADY && PWRITE && PADDR == 12'h000; endsequence
    property p_rdy; s_set |=> PREADY; endproperty
    property p_idle; !(PSEL && !PENABLE) |=> !PREADY; endproperty
    property p_bad; s_set ##0 (PADDR == 12'h020 && !PWRITE) |=> PSLVERR && !PRDATA; endproperty
    property p_hold; PREADY |=> $stable(PRDATA); endproperty
    property p_gate; s_cwr ##0 !PWDATA[1] |-> ##2 (!TICK_IRQ) [*2]; endproperty
    property p_dis; s_cwr ##0 PWDATA[1:0] == 2'h2 |-> ##3 (!$rose(TICK_IRQ)) [*8]; endproperty
    property p_hand; $rose(HANDLER_ENTRY) |-> ##2 !TICK_IRQ; endproperty
    property p_clr; PSEL && PREADY && !PWRITE && PADDR == 12'h00C |-> ##2 !EVENT_IRQ; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    a_idle: assert property (p_idle) else $error("stray ready");
    a_bad: assert property (p_bad) else $error("bad address");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_gate: assert property (p_gate) else $error("tick not gated");
    a_dis: assert property (p_dis) else $error("tick while stopped");
    a_hand: assert property (p_hand) else $error("tick not cleared");
    a_clr: assert property (p_clr) else $error("event not cleared");
endmodule // stk_chk
bind stk_top stk_chk #(.CNT_W(CNT_W)) i_chk (.CLOCK, .RST_B, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HANDLER_ENTRY, .TICK_IRQ, .EVENT_IRQ);
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin \
    checks_done++; \
    if ((x) !== (y)) begin \
        fails++; \
        $display("CHECK FAILED t=%0t %h %h", $time, x, y); \
    end \
end
// The model steps the count back by the fixed three-cycle read spacing, modulo the period.
module tb;
    logic        CLOCK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, HANDLER_ENTRY = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA, q, a, per;
    logic        PREADY, PSLVERR, TICK_IRQ, EVENT_IRQ, err;
    int          fails = 0, checks_done = 0, n, i;
    stk_top i_stk_top (.CLOCK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
        .PREADY, .PSLVERR, .HANDLER_ENTRY, .TICK_IRQ, .EVENT_IRQ);
    initial forever #4 CLOCK = ~CLOCK;
    task automatic results;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One transfer; the idle edge at the end keeps two drives of a strobe apart.
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        for (n = 0; n < 16 && PREADY !== 1'b1; n++) @(posedge CLOCK);
        `CHK(n < 16, 1'b1)
        if (n == 16) results();
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLOCK);
    endtask
    initial begin
        void'($urandom(32'h106fc91d));
        per = 32'd40 + $urandom % 100;
        repeat (12) @(posedge CLOCK);
        RST_B <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        `CHK(q, 32'h1)
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, q}, 33'h100000000)
        apb(1'b1, 12'h004, per);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(q, per)
        apb(1'b1, 12'h008, $urandom);
        apb(1'b1, 12'h000, 32'h1);
        // Enough reads to cross at least one rollover.
        for (i = 0; i < 60; i++) begin
            a = q;
            apb(1'b0, 12'h008, 32'h0);
            `CHK(q < per, 1'b1)
            if (i > 0) `CHK(q, (a + per - 32'd3) % per)
        end
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        a = q;
        apb(1'b0, 12'h008, 32'h0);
        `CHK(q, a)
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        `CHK((a + per - q) % per < 8, 1'b1)
        apb(1'b1, 12'h004, per + 32'd23);
        apb(1'b1, 12'h008, $urandom);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(q < per + 23 && q > per + 15, 1'b1)
        // Stop the counter so no new event races the status read.
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h010, 32'h1);
        for (n = 0; n < 300 && EVENT_IRQ !== 1'b1; n++) @(posedge CLOCK);
        `CHK({EVENT_IRQ, TICK_IRQ}, 2'h2)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(q[1:0], 2'h3)
        `CHK(EVENT_IRQ, 1'b0)
        apb(1'b1, 12'h000, 32'h2);
        for (n = 0; n < 300 && TICK_IRQ !== 1'b1; n++) @(posedge CLOCK);
        `CHK(TICK_IRQ, 1'b1)
        HANDLER_ENTRY <= 1'b1;
        @(posedge CLOCK);
        HANDLER_ENTRY <= 1'b0;
        @(posedge CLOCK);
        `CHK(TICK_IRQ, 1'b0)
        apb(1'b1, 12'h000, 32'h3);
        for (n = 0; n < 400 && TICK_IRQ !== 1'b1; n++) @(posedge CLOCK);
        `CHK(TICK_IRQ, 1'b1)
        HANDLER_ENTRY <= 1'b1;
        @(posedge CLOCK);
        HANDLER_ENTRY <= 1'b0;
        @(posedge CLOCK);
        `CHK(TICK_IRQ, 1'b0)
        // The next tick is seen one period after the last, less the two edges above.
        for (n = 0; n < 400 && TICK_IRQ !== 1'b1; n++) @(posedge CLOCK);
        `CHK(n, per + 32'd21)
        apb(1'b1, 12'h000, 32'h2);
        HANDLER_ENTRY <= 1'b1;
        @(posedge CLOCK);
        HANDLER_ENTRY <= 1'b0;
        repeat (300) @(posedge CLOCK);
        `CHK(TICK_IRQ, 1'b0)
        results();
    end
endmodule // tb
`default_nettype wire
